// [hw/atx_exec.v]
// accumulator transfer instruction executor with an AHB-Lite register slave
// How it works
// - load-wake-ctl-b copies accumulator, one cycle
// - store writes accumulator to RAM at pointer
// - then low pointer becomes pointer XOR immediate
// - load-clock-ctl copies accumulator into clock control
// - timer bit takes accumulator bit zero only
// - prescaler pair gets B high, A low
`timescale 1ns/1ps
`default_nettype none
`include "atx_map.vh"

module atx_exec #(
    parameter RAM_AW = 8
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata_ff,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [3:0]  keyon_wake_ctl_b_ff,
    output reg  [3:0]  clock_ctl_reg_ff,
    output reg         timer_ctl_bit_reg_ff,
    output reg  [7:0]  prescaler_ff,
    output reg  [7:0]  prescaler_reload_reg_ff,
    output reg         carry_flag_ff,
    output reg         skip_next_ff,
    output reg         instr_done_ff
);

    // ----------------------------------------------------------------
    // core state
    // ----------------------------------------------------------------
    reg  [3:0]        acc_ff;
    reg  [3:0]        regb_ff;
    reg  [3:0]        ptr_x_ff;
    reg  [3:0]        ptr_y_ff;
    reg  [7:0]        last_instr_ff;
    reg               bad_op_ff;

    // bus pipeline state
    reg               wr_pend_ff;
    reg  [7:0]        wr_addr_ff;
    reg               rd_pend_ff;
    reg  [31:0]       rd_val;

    wire              addr_ph;
    wire [7:0]        addr_word;
    wire              wr_en;
    wire              exec;
    wire [3:0]        op;
    wire [3:0]        imm;
    wire [RAM_AW-1:0] data_pointer;
    wire              ram_we;
    wire [3:0]        ram_rdata;

    // ----------------------------------------------------------------
    // AHB-Lite slave
    // ----------------------------------------------------------------
    // only nonseq/seq with hready high is a real address phase
    assign addr_ph   = hsel & htrans[1] & hready;
    assign addr_word = {haddr[7:2], 2'b00};
    // one wait state only for the ram window, whose read port lags a cycle
    assign hreadyout = ~rd_pend_ff;
    assign hresp     = 1'b0;
    assign wr_en     = wr_pend_ff;

    // address phase capture and read data register
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= `ATX_RST_BYTE;
            rd_pend_ff <= 1'b0;
            hrdata_ff  <= `ATX_RST_WORD;
        end else begin
            wr_pend_ff <= addr_ph & hwrite;
            if (addr_ph & hwrite) begin
                wr_addr_ff <= addr_word;
            end
            if (rd_pend_ff) begin
                rd_pend_ff <= 1'b0;
                hrdata_ff  <= {28'h0000000, ram_rdata};
            end else if (addr_ph & ~hwrite) begin
                if (addr_word == `ATX_OFS_RAMDATA) begin
                    rd_pend_ff <= 1'b1;
                end else begin
                    hrdata_ff <= rd_val;
                end
            end
        end
    end

    // read mux; unmapped offsets read zero with an okay answer
    always @* begin
        rd_val = 32'h0000_0000;
        case (addr_word)
            `ATX_OFS_INSTR:  rd_val = {24'h000000, last_instr_ff};
            `ATX_OFS_ACC:    rd_val = {28'h0000000, acc_ff};
            `ATX_OFS_REGB:   rd_val = {28'h0000000, regb_ff};
            `ATX_OFS_DPTR:   rd_val = {24'h000000, ptr_y_ff, ptr_x_ff};
            `ATX_OFS_WAKE_B: rd_val = {28'h0000000, keyon_wake_ctl_b_ff};
            `ATX_OFS_CLKCTL: rd_val = {28'h0000000, clock_ctl_reg_ff};
            `ATX_OFS_TMRBIT: rd_val = {31'h0, timer_ctl_bit_reg_ff};
            `ATX_OFS_PRESC:  rd_val = {16'h0000, prescaler_reload_reg_ff, prescaler_ff};
            `ATX_OFS_CARRY:  rd_val = {31'h0, carry_flag_ff};
            `ATX_OFS_STATUS: rd_val = {30'h0, bad_op_ff, skip_next_ff};
            default:         rd_val = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------------------------------
    // instruction decode
    // ----------------------------------------------------------------
    // a write to the instruction register executes in that single cycle
    assign exec = wr_en & (wr_addr_ff == `ATX_OFS_INSTR);
    assign op   = hwdata[`ATX_INSTR_OP_MSB:`ATX_INSTR_OP_LSB];
    assign imm  = hwdata[`ATX_INSTR_IMM_MSB:`ATX_INSTR_IMM_LSB];

    // ram write uses the pointer as it stands before the flip
    assign data_pointer = {ptr_y_ff, ptr_x_ff};
    assign ram_we       = exec & (op == `ATX_OP_STORE_ACC_FLIP_PTR);

    // software loads of the operand registers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_ff        <= `ATX_RST_NIBBLE;
            regb_ff       <= `ATX_RST_NIBBLE;
            ptr_y_ff      <= `ATX_RST_NIBBLE;
            carry_flag_ff <= `ATX_RST_BIT;
        end else if (wr_en) begin
            case (wr_addr_ff)
                `ATX_OFS_ACC:   acc_ff        <= hwdata[3:0];
                `ATX_OFS_REGB:  regb_ff       <= hwdata[3:0];
                `ATX_OFS_DPTR:  ptr_y_ff      <= hwdata[`ATX_DPTR_Y_MSB:`ATX_DPTR_Y_LSB];
                `ATX_OFS_CARRY: carry_flag_ff <= hwdata[0];
                default: ;
            endcase
        end
    end

    // low pointer: direct load, or flip by the immediate after the store
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ptr_x_ff <= `ATX_RST_NIBBLE;
        end else if (ram_we) begin
            ptr_x_ff <= ptr_x_ff ^ imm;
        end else if (wr_en && (wr_addr_ff == `ATX_OFS_DPTR)) begin
            ptr_x_ff <= hwdata[`ATX_DPTR_X_MSB:`ATX_DPTR_X_LSB];
        end
    end

    // destination registers of the transfer group
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            keyon_wake_ctl_b_ff     <= `ATX_RST_NIBBLE;
            clock_ctl_reg_ff        <= `ATX_RST_NIBBLE;
            timer_ctl_bit_reg_ff    <= `ATX_RST_BIT;
            prescaler_ff            <= `ATX_RST_BYTE;
            prescaler_reload_reg_ff <= `ATX_RST_BYTE;
        end else if (exec) begin
            case (op)
                `ATX_OP_LOAD_WAKE_CTL_B: begin
                    keyon_wake_ctl_b_ff <= acc_ff;
                end
                `ATX_OP_LOAD_CLOCK_CTL: begin
                    clock_ctl_reg_ff <= acc_ff;
                end
                `ATX_OP_LOAD_TIMER_CTL_BIT: begin
                    timer_ctl_bit_reg_ff <= acc_ff[0];
                end
                `ATX_OP_LOAD_PRESCALER_PAIR: begin
                    prescaler_ff            <= {regb_ff, acc_ff};
                    prescaler_reload_reg_ff <= {regb_ff, acc_ff};
                end
                default: ;
            endcase
        end
    end

    // completion pulse, last instruction and illegal-op status
    // carry is never touched here and skip stays low for this group
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            instr_done_ff <= 1'b0;
            skip_next_ff  <= 1'b0;
            last_instr_ff <= `ATX_RST_BYTE;
            bad_op_ff     <= 1'b0;
        end else begin
            instr_done_ff <= exec;
            if (exec) begin
                skip_next_ff  <= 1'b0;
                last_instr_ff <= hwdata[7:0];
                bad_op_ff     <= (op == 4'h0) || (op > `ATX_OP_LOAD_PRESCALER_PAIR);
            end
        end
    end

    // ----------------------------------------------------------------
    // data memory
    // ----------------------------------------------------------------
    atx_nibble_ram #(
        .AW (RAM_AW),
        .DW (4)
    ) u_ram (
        .clk      (hclk),
        .rst_n    (hresetn),
        .we       (ram_we),
        .waddr    (data_pointer),
        .wdata    (acc_ff),
        .raddr    (data_pointer),
        .rdata_ff (ram_rdata)
    );

endmodule

`default_nettype wire

// [hw/atx_map.vh]
// register offsets, field positions, reset values and command codes of the transfer executor
`ifndef ATX_MAP_VH
`define ATX_MAP_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ATX_OFS_INSTR      8'h00
`define ATX_OFS_ACC        8'h04
`define ATX_OFS_REGB       8'h08
`define ATX_OFS_DPTR       8'h0c
`define ATX_OFS_WAKE_B     8'h10
`define ATX_OFS_CLKCTL     8'h14
`define ATX_OFS_TMRBIT     8'h18
`define ATX_OFS_PRESC      8'h1c
`define ATX_OFS_CARRY      8'h20
`define ATX_OFS_RAMDATA    8'h24
`define ATX_OFS_STATUS     8'h28

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ATX_INSTR_OP_MSB   7
`define ATX_INSTR_OP_LSB   4
`define ATX_INSTR_IMM_MSB  3
`define ATX_INSTR_IMM_LSB  0
`define ATX_DPTR_Y_MSB     7
`define ATX_DPTR_Y_LSB     4
`define ATX_DPTR_X_MSB     3
`define ATX_DPTR_X_LSB     0
`define ATX_PRESC_RLD_MSB  15
`define ATX_PRESC_RLD_LSB  8
`define ATX_STAT_SKIP_BIT  0
`define ATX_STAT_BAD_BIT   1

// ----------------------------------------------------------------
// command codes in the op field
// ----------------------------------------------------------------
`define ATX_OP_LOAD_WAKE_CTL_B     4'h1
`define ATX_OP_STORE_ACC_FLIP_PTR  4'h2
`define ATX_OP_LOAD_CLOCK_CTL      4'h3
`define ATX_OP_LOAD_TIMER_CTL_BIT  4'h4
`define ATX_OP_LOAD_PRESCALER_PAIR 4'h5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ATX_RST_NIBBLE     4'h0
`define ATX_RST_BYTE       8'h00
`define ATX_RST_BIT        1'b0
`define ATX_RST_WORD       32'h0000_0000

`endif

// [hw/atx_nibble_ram.v]
// nibble data memory addressed by the data pointer, registered read port
`timescale 1ns/1ps
`default_nettype none

module atx_nibble_ram #(
    parameter AW = 8,
    parameter DW = 4
) (
    input  wire          clk,
    input  wire          rst_n,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    input  wire [AW-1:0] raddr,
    output reg  [DW-1:0] rdata_ff
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    // ----------------------------------------------------------------
    // write port; array has no reset, software must initialise it
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // read data always comes from a register, one cycle behind raddr
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= {DW{1'b0}};
        end else begin
            rdata_ff <= mem[raddr];
        end
    end

endmodule

`default_nettype wire

// [test/atx_exec_chk.sv]
// checker binding the executor ports to its transfer rules
`timescale 1ns/1ps
`default_nettype none
module atx_chk #(
    parameter RAM_AW = 8
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [3:0]  keyon_wake_ctl_b_ff,
    input wire logic [3:0]  clock_ctl_reg_ff,
    input wire logic        timer_ctl_bit_reg_ff,
    input wire logic [7:0]  prescaler_ff,
    input wire logic [7:0]  prescaler_reload_reg_ff,
    input wire logic        carry_flag_ff,
    input wire logic        skip_next_ff,
    input wire logic        instr_done_ff
);
    // ----
    // data phase tracking
    // ----
    logic       inst_ff;
    logic       cary_ff;
    wire  [3:0] op = hwdata[7:4];
    wire        iw = inst_ff & hready;
    wire        cw = cary_ff & hready;
    // the address only holds while hready is low, so latch it on hready
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            inst_ff <= 1'b0;
            cary_ff <= 1'b0;
        end else if (hready) begin
            inst_ff <= hsel & htrans[1] & hwrite & (haddr[7:0] == 8'h00);
            cary_ff <= hsel & htrans[1] & hwrite & (haddr[7:0] == 8'h20);
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_done_pulse:
        assert property (instr_done_ff == $past(iw)) else $error("done pulse misplaced");
    a_wake_load:
        assert property (!$stable(keyon_wake_ctl_b_ff) |-> $past(iw && op == 4'h1))
        else $error("wake control changed without load");
    a_clk_load:
        assert property (!$stable(clock_ctl_reg_ff) |-> $past(iw && op == 4'h3))
        else $error("clock control changed without load");
    a_tmr_load:
        assert property (!$stable(timer_ctl_bit_reg_ff) |-> $past(iw && op == 4'h4))
        else $error("timer bit changed without load");
    a_presc_load:
        assert property (!$stable(prescaler_ff) |-> $past(iw && op == 4'h5))
        else $error("prescaler changed without load");
    a_presc_pair:
        assert property (prescaler_ff == prescaler_reload_reg_ff)
        else $error("prescaler and reload differ");
    a_carry_keep:
        assert property (!$stable(carry_flag_ff) |-> $past(cw))
        else $error("carry changed by an instruction");
    a_skip_never:
        assert property (skip_next_ff == 1'b0) else $error("skip raised");
endmodule

bind atx_exec atx_chk #(.RAM_AW(RAM_AW)) u_atx_chk (.*);
`default_nettype wire

// [test/tb_top.sv]
// self-checking bench for the transfer executor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata_ff;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  keyon_wake_ctl_b_ff, clock_ctl_reg_ff;
    logic [7:0]  prescaler_ff, prescaler_reload_reg_ff;
    logic        timer_ctl_bit_reg_ff, carry_flag_ff, skip_next_ff, instr_done_ff;
    int          fails, num_checks, cyc;

    // the one slave drives the bus ready
    assign hready = hreadyout;
    atx_exec #(.RAM_AW(8)) dut (.*);

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // the run needs about 130 cycles, so this only cuts a hang
    always @(posedge hclk) begin
        cyc++;
        if (cyc > 3000) begin
            fails++;
            test_done();
        end
    end

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    // single word transfer; each phase held until ready is sampled high
    task xfer(input logic w, input logic [7:0] a, inout logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (!hreadyout);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (!hreadyout);
        chk("hresp", 32'h0, 32'(hresp));
        d = hrdata_ff;
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] d;
        d = v;
        xfer(1'b1, a, d);
    endtask
    task rd(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        d = 32'h0;
        xfer(1'b0, a, d);
        chk(n, e, d);
    endtask
    // load the accumulator, then execute one instruction byte
    task ex(input logic [3:0] op, input logic [3:0] j, input logic [3:0] a);
        wr(8'h04, {28'h0, a});
        wr(8'h00, {24'h0, op, j});
    endtask

    task t_wake;
        ex(4'h1, 4'h0, 4'hf);
        chk("done", 32'h1, 32'(instr_done_ff));
        chk("wake", 32'hf, 32'(keyon_wake_ctl_b_ff));
        ex(4'h1, 4'h5, 4'h6);
        chk("wake", 32'h6, 32'(keyon_wake_ctl_b_ff));
    endtask
    // a store must land at the old pointer before the low nibble flips
    task t_store;
        wr(8'h0c, 32'h35);
        ex(4'h2, 4'hf, 4'h1);
        ex(4'h2, 4'hf, 4'h7);
        rd("dptr", 8'h0c, 32'h35);
        rd("ram", 8'h24, 32'h1);
        wr(8'h0c, 32'h3a);
        rd("ram", 8'h24, 32'h7);
        ex(4'h2, 4'h0, 4'h9);
        rd("dptr", 8'h0c, 32'h3a);
        rd("ram", 8'h24, 32'h9);
    endtask
    task t_clk;
        ex(4'h3, 4'h0, 4'hc);
        chk("clkctl", 32'hc, 32'(clock_ctl_reg_ff));
    endtask
    task t_tmr;
        ex(4'h4, 4'h0, 4'hf);
        chk("tmrbit", 32'h1, 32'(timer_ctl_bit_reg_ff));
        ex(4'h4, 4'h0, 4'he);
        chk("tmrbit", 32'h0, 32'(timer_ctl_bit_reg_ff));
    endtask
    task t_presc;
        wr(8'h08, 32'ha);
        ex(4'h5, 4'h0, 4'h5);
        chk("presc", 32'ha5, 32'(prescaler_ff));
        chk("reload", 32'ha5, 32'(prescaler_reload_reg_ff));
        rd("prescreg", 8'h1c, 32'ha5a5);
    endtask
    // carry set by software must survive instructions; an illegal op sets the status bad bit, other odd accesses do nothing
    task t_flags;
        wr(8'h20, 32'h1);
        ex(4'h1, 4'h0, 4'h3);
        ex(4'h2, 4'h3, 4'h4);
        chk("carry", 32'h1, 32'(carry_flag_ff));
        chk("skip", 32'h0, 32'(skip_next_ff));
        ex(4'h9, 4'h0, 4'h0);
        rd("status", 8'h28, 32'h2);
        wr(8'h10, 32'h5);
        rd("wakereg", 8'h10, 32'h3);
        rd("unmapped", 8'h3c, 32'h0);
    endtask
    // a reset in mid-run clears wake, clock control, prescaler pair, carry and read data and leaves ready high, then the block works again
    task t_reset;
        @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        #1;
        chk("wake_rst", 32'h0, 32'(keyon_wake_ctl_b_ff));
        chk("clk_rst", 32'h0, 32'(clock_ctl_reg_ff));
        chk("presc_rst", 32'h0, 32'({prescaler_reload_reg_ff, prescaler_ff}));
        chk("carry_rst", 32'h0, 32'(carry_flag_ff));
        chk("rdata_rst", 32'h0, hrdata_ff);
        chk("ready_rst", 32'h1, 32'(hreadyout));
        @(posedge hclk);
        hresetn <= 1'b1;
        ex(4'h3, 4'h0, 4'h7);
        chk("clkctl", 32'h7, 32'(clock_ctl_reg_ff));
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        {fails, num_checks, cyc} = '0;
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_wake();
        t_store();
        t_clk();
        t_tmr();
        t_presc();
        t_flags();
        t_reset();
        test_done();
    end
endmodule
`default_nettype wire
